// ---- rtl/ops_stage.sv ----
/*
 * ops_stage: one overpower protection stage with APB register slave,
 * event serialiser, counters and a twelve-record operation log.
 * Assumes all inputs synchronous to clock; date_in/time_ms_in come from an RTC.
 */
// Decided for this implementation: the APB slave port and the address map.
// Function
// - start when measured power exceeds the pick-up threshold
// - threshold in 0.01 kW steps, minimum 0.01 kW, default 100 kW
// - ratio of power to threshold kept with 0.01 resolution
// - started stage releases only below 97 percent of threshold
// - setting changes take effect while running, no stop needed
// - status is one of normal, start, trip, blocked
// - expected operating time reported in 5 ms steps
// - signed remaining time to trip reported in 5 ms steps
// - blocking input sampled once at start of each processing cycle
// - pick-up without block gives start and begins timing
// - pick-up with block gives blocked, nothing further
// - block while started drops start via release timing
// - definite time only, for trip and for reset
// - ON and OFF events for start, trip, block, each maskable
// - each event carries a time stamp
// - resettable counters of start, trip, blocked
// - start, trip, blocked offered as outputs
// - exactly one independent stage
// - keep last twelve records, ON transitions only, oldest replaced
// - record holds event, pre-trigger, fault, pre-fault power, remaining, group
// - record stamp holds date and millisecond time of day
// - power derived from fundamental phase currents and voltages
// - forcing enabled sets status from a static setting, default normal
`timescale 1ns/10ps
module ops_stage
  import ops_pkg::*;
#(
  parameter int unsigned P_CYCLE_CLKS = CYCLE_CLKS
) (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic signed [15:0] i_l1,
  input  wire logic signed [15:0] i_l2,
  input  wire logic signed [15:0] i_l3,
  input  wire logic [15:0]        u_l1,
  input  wire logic [15:0]        u_l2,
  input  wire logic [15:0]        u_l3,
  input  wire logic               block_in,
  input  wire logic [2:0]         setting_group,
  input  wire logic [31:0]        date_in,
  input  wire logic [31:0]        time_ms_in,
  output logic                    start_out,
  output logic                    trip_out,
  output logic                    blocked_out,
  output logic [1:0]              status_out,
  output logic                    event_valid,
  output logic [2:0]              event_code,
  output logic [31:0]             event_date,
  output logic [31:0]             event_time
);
  logic [31:0]        div_q, thr_q, opd_q, rsd_q, timer_q, tmr_d, rel_q, rel_d;
  logic [31:0]        ratio_q, prdata_q, rd_d, pm_u;
  logic signed [31:0] pm_q, pm_calc, rem_q;
  logic signed [31:0] prod [3];
  logic signed [15:0] i_ph [3];
  logic [15:0]        u_ph [3];
  logic signed [33:0] p_sum;
  logic signed [31:0] hist_q [PRE_FAULT_CYC];
  logic [39:0]        pm100, thr97, thr100;
  logic               tick, eval_q, blk_q, pick_on, pick_hold, force_en_q, err_q, hit;
  logic [1:0]         force_st_q;
  logic [5:0]         mask_q, pend_q, raise, clr_oh;
  logic [2:0]         flags, prev_q, on_e, off_e, ev_sel, cnt_clr;
  logic               emit, ev_valid_q;
  logic [2:0]         ev_code_q;
  logic [31:0]        ev_date_q, ev_time_q;
  logic [15:0]        cnt_q [3];
  logic [3:0]         wr_ptr_q, lg_cnt_q, lsel_q, rd_idx;
  logic [4:0]         rd_tmp;
  logic               wr_acc, setup;
  ops_status_type     state_q, st_d, status_q, disp;
  // log storage, one array per field
  logic [2:0]         lg_code [LOG_DEPTH];
  logic [2:0]         lg_grp  [LOG_DEPTH];
  logic signed [31:0] lg_pre  [LOG_DEPTH];
  logic signed [31:0] lg_flt  [LOG_DEPTH];
  logic signed [31:0] lg_pref [LOG_DEPTH];
  logic signed [31:0] lg_rem  [LOG_DEPTH];
  logic [31:0]        lg_date [LOG_DEPTH];
  logic [31:0]        lg_time [LOG_DEPTH];

  // processing cycle strobe; one shared stage, no channel replication
  assign tick = (div_q == 32'(P_CYCLE_CLKS - 1));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 32'h0;
      eval_q <= 1'b0;
    end else begin
      div_q  <= tick ? 32'h0 : div_q + 32'h1;
      eval_q <= tick;
    end
  end

  // in-phase current times voltage per phase gives watts
  assign i_ph[0] = i_l1;
  assign i_ph[1] = i_l2;
  assign i_ph[2] = i_l3;
  assign u_ph[0] = u_l1;
  assign u_ph[1] = u_l2;
  assign u_ph[2] = u_l3;
  for (genvar g = 0; g < 3; g++) begin : g_ph
    assign prod[g] = i_ph[g] * $signed({16'h0000, u_ph[g]});
  end
  // 34 bits so three full-scale phases cannot wrap
  assign p_sum   = 34'(prod[0]) + 34'(prod[1]) + 34'(prod[2]);
  assign pm_calc = 32'(p_sum / $signed(34'(WATT_PER_LSB)));

  // sample power and block together at the head of the cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pm_q  <= 32'sh0;
      blk_q <= 1'b0;
    end else if (tick) begin
      pm_q  <= pm_calc;
      blk_q <= block_in;
    end
  end

  // power history, one entry per processing cycle
  for (genvar k = 0; k < PRE_FAULT_CYC; k++) begin : g_hist
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        hist_q[k] <= 32'sh0;
      end else if (tick) begin
        hist_q[k] <= (k == 0) ? pm_q : hist_q[(k == 0) ? 0 : k - 1];
      end
    end
  end

  // comparisons scaled by 100 so the 97 % point needs no divider
  assign pm_u      = pm_q[31] ? 32'h0 : pm_q;
  assign pm100     = 40'(pm_u) * 40'(RATIO_SCALE);
  assign thr97     = 40'(thr_q) * 40'(RESET_PCT);
  assign thr100    = 40'(thr_q) * 40'(RATIO_SCALE);
  assign pick_on   = pm100 > thr100;
  assign pick_hold = pm100 >= thr97;

  // ratio and remaining time refresh every cycle; wide divider is the cost
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ratio_q <= 32'h0;
      rem_q   <= 32'sh0;
    end else if (eval_q) begin
      ratio_q <= 32'(pm100 / 40'(thr_q));
      // next-state view, so the value shown matches the status that follows
      rem_q   <= (st_d == ST_START) ? $signed(opd_q - tmr_d) : 32'sh0;
    end
  end

  // definite-time state machine, evaluated once per processing cycle
  always_comb begin
    st_d  = state_q;
    tmr_d = timer_q;
    rel_d = rel_q;
    if (eval_q) begin
      case (state_q)
        ST_NORMAL: begin
          tmr_d = 32'h0;
          rel_d = 32'h0;
          if (pick_on) begin
            st_d = blk_q ? ST_BLOCKED : ST_START;
          end
        end
        ST_START, ST_TRIP: begin
          if (pick_hold && !blk_q) begin
            rel_d = 32'h0;
            if (state_q == ST_START) begin
              if (timer_q + 32'h1 >= opd_q) begin
                st_d = ST_TRIP;
              end else begin
                tmr_d = timer_q + 32'h1;
              end
            end
          end else if (rel_q >= rsd_q) begin
            st_d  = ST_NORMAL;
            tmr_d = 32'h0;
            rel_d = 32'h0;
          end else begin
            rel_d = rel_q + 32'h1;
          end
        end
        ST_BLOCKED: begin
          if (!pick_hold) begin
            st_d = ST_NORMAL;
          end else if (!blk_q) begin
            st_d  = ST_START;
            tmr_d = 32'h0;
          end
        end
        default: st_d = ST_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_NORMAL;
      timer_q <= 32'h0;
      rel_q   <= 32'h0;
    end else begin
      state_q <= st_d;
      timer_q <= tmr_d;
      rel_q   <= rel_d;
    end
  end

  // forcing overrides only what is shown, the timing keeps running
  assign disp = force_en_q ? ops_status_type'(force_st_q) : state_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= ST_NORMAL;
    end else begin
      status_q <= disp;
    end
  end
  assign status_out  = status_q;
  assign start_out   = (status_q == ST_START) || (status_q == ST_TRIP);
  assign trip_out    = (status_q == ST_TRIP);
  assign blocked_out = (status_q == ST_BLOCKED);

  // edges of the three outputs become pending event bits
  assign flags = {blocked_out, trip_out, start_out};
  assign on_e  = flags & ~prev_q;
  assign off_e = ~flags & prev_q;
  for (genvar k = 0; k < 3; k++) begin : g_ev
    assign raise[2*k]   = on_e[k];
    assign raise[2*k+1] = off_e[k];
  end

  // lowest pending bit goes out first, one per clock
  always_comb begin
    ev_sel = 3'h0;
    for (int n = 5; n >= 0; n--) begin
      if (pend_q[n]) begin
        ev_sel = 3'(n);
      end
    end
  end
  assign emit   = |pend_q;
  assign clr_oh = emit ? (6'h01 << ev_sel) : 6'h00;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 3'h0;
      pend_q <= 6'h00;
    end else begin
      prev_q <= flags;
      pend_q <= (pend_q & ~clr_oh) | raise; // new edge wins over clear
    end
  end

  // event port to the main buffer, stamped on the way out
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ev_valid_q <= 1'b0;
      ev_code_q  <= 3'h0;
      ev_date_q  <= 32'h0;
      ev_time_q  <= 32'h0;
    end else begin
      ev_valid_q <= emit && mask_q[ev_sel];
      if (emit) begin
        ev_code_q <= ev_sel;
        ev_date_q <= date_in;
        ev_time_q <= time_ms_in;
      end
    end
  end
  assign event_valid = ev_valid_q;
  assign event_code  = ev_code_q;
  assign event_date  = ev_date_q;
  assign event_time  = ev_time_q;

  // cumulative counters; an edge in the clearing cycle still counts
  for (genvar k = 0; k < 3; k++) begin : g_cnt
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        cnt_q[k] <= 16'h0;
      end else if (cnt_clr[k]) begin
        cnt_q[k] <= on_e[k] ? 16'h1 : 16'h0;
      end else if (on_e[k]) begin
        cnt_q[k] <= cnt_q[k] + 16'h1;
      end
    end
  end

  // log ring: ON events only, masked or not, oldest overwritten
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= 4'h0;
      lg_cnt_q <= 4'h0;
    end else if (emit && !ev_sel[0]) begin
      wr_ptr_q <= (wr_ptr_q == 4'(LOG_DEPTH - 1)) ? 4'h0 : wr_ptr_q + 4'h1;
      if (lg_cnt_q != 4'(LOG_DEPTH)) begin
        lg_cnt_q <= lg_cnt_q + 4'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (emit && !ev_sel[0]) begin
      lg_code[wr_ptr_q] <= ev_sel;
      lg_pre[wr_ptr_q]  <= hist_q[PRE_TRIG_CYC - 1];
      lg_flt[wr_ptr_q]  <= pm_q;
      lg_pref[wr_ptr_q] <= hist_q[PRE_FAULT_CYC - 1];
      lg_rem[wr_ptr_q]  <= rem_q;
      lg_grp[wr_ptr_q]  <= setting_group;
      lg_date[wr_ptr_q] <= date_in;
      lg_time[wr_ptr_q] <= time_ms_in;
    end
  end
  // selector 0 is the newest record
  assign rd_tmp = {1'b0, wr_ptr_q} + 5'(LOG_DEPTH - 1) - {1'b0, lsel_q};
  assign rd_idx = (rd_tmp >= 5'(LOG_DEPTH)) ? 4'(rd_tmp - 5'(LOG_DEPTH)) : rd_tmp[3:0];

  // apb writes take effect at the access edge; settings apply live
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite;
  assign cnt_clr = (wr_acc && paddr == OFS_CLR) ? pwdata[2:0] : 3'h0;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      force_en_q <= 1'b0;
      force_st_q <= 2'h0;
      thr_q      <= THR_RST;
      opd_q      <= OPD_RST;
      rsd_q      <= RSD_RST;
      mask_q     <= MASK_RST;
      lsel_q     <= 4'h0;
    end else if (wr_acc) begin
      case (paddr)
        OFS_CTRL: begin
          force_en_q <= pwdata[CTRL_FORCE_EN];
          force_st_q <= pwdata[CTRL_FORCE_LO +: 2];
        end
        OFS_THR:  thr_q  <= (pwdata == 32'h0) ? 32'h1 : pwdata;
        OFS_OPD:  opd_q  <= pwdata;
        OFS_RSD:  rsd_q  <= pwdata;
        OFS_MASK: mask_q <= pwdata[5:0];
        OFS_LSEL: lsel_q <= (pwdata >= 32'(LOG_DEPTH)) ? 4'(LOG_DEPTH - 1) : pwdata[3:0];
        default: ;
      endcase
    end
  end

  // read mux; records not yet written read as zero
  always_comb begin
    rd_d = 32'h0;
    hit  = 1'b1;
    case (paddr)
      OFS_CTRL:   rd_d = {29'h0, force_st_q, force_en_q};
      OFS_THR:    rd_d = thr_q;
      OFS_OPD:    rd_d = opd_q;
      OFS_RSD:    rd_d = rsd_q;
      OFS_MASK:   rd_d = {26'h0, mask_q};
      OFS_CLR:    rd_d = 32'h0;
      OFS_STAT:   rd_d = {28'h0, blk_q, 1'b0, status_q};
      OFS_POWER:  rd_d = pm_q;
      OFS_RATIO:  rd_d = ratio_q;
      OFS_EXPECT: rd_d = opd_q;
      OFS_REMAIN: rd_d = rem_q;
      OFS_CNT0:   rd_d = {16'h0, cnt_q[0]};
      OFS_CNT1:   rd_d = {16'h0, cnt_q[1]};
      OFS_CNT2:   rd_d = {16'h0, cnt_q[2]};
      OFS_LSEL:   rd_d = {28'h0, lsel_q};
      OFS_LINFO:  rd_d = (lsel_q < lg_cnt_q) ?
                         {20'h0, lg_cnt_q, 1'b0, lg_grp[rd_idx], 1'b0, lg_code[rd_idx]} :
                         {20'h0, lg_cnt_q, 8'h00};
      OFS_LPRE:   rd_d = (lsel_q < lg_cnt_q) ? lg_pre[rd_idx] : 32'h0;
      OFS_LFLT:   rd_d = (lsel_q < lg_cnt_q) ? lg_flt[rd_idx] : 32'h0;
      OFS_LPREF:  rd_d = (lsel_q < lg_cnt_q) ? lg_pref[rd_idx] : 32'h0;
      OFS_LREM:   rd_d = (lsel_q < lg_cnt_q) ? lg_rem[rd_idx] : 32'h0;
      OFS_LDATE:  rd_d = (lsel_q < lg_cnt_q) ? lg_date[rd_idx] : 32'h0;
      OFS_LTIME:  rd_d = (lsel_q < lg_cnt_q) ? lg_time[rd_idx] : 32'h0;
      default:    hit  = 1'b0;
    endcase
  end

  // data latched in setup so access completes with no wait state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
      err_q    <= 1'b0;
    end else if (setup) begin
      prdata_q <= rd_d;
      err_q    <= !hit;
    end
  end
  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_q;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_emit_start;
    emit && ev_sel == EV_START_ON;
  endsequence
  chk_pickup_start: assert property (
    eval_q && state_q == ST_NORMAL && pick_on && !blk_q |=> state_q == ST_START ##1
    status_q == ST_START || force_en_q) else $error("pick-up did not start");
  chk_pickup_block: assert property (
    eval_q && state_q == ST_NORMAL && pick_on && blk_q |=> state_q == ST_BLOCKED)
    else $error("blocked pick-up not flagged");
  chk_delay_trip: assert property (
    eval_q && state_q == ST_START && pick_hold && !blk_q && timer_q + 32'h1 >= opd_q
    |=> state_q == ST_TRIP) else $error("trip not taken after delay");
  chk_hyst_hold: assert property (
    eval_q && state_q == ST_START && pick_hold && !blk_q |=> state_q != ST_NORMAL)
    else $error("released above reset level");
  chk_block_drop: assert property (
    eval_q && state_q == ST_START && blk_q && rsd_q == 32'h0 |=> state_q == ST_NORMAL
    && timer_q == 32'h0) else $error("block did not release start");
  chk_block_sample: assert property (
    eval_q |-> blk_q == $past(block_in)) else $error("block not sampled at cycle head");
  chk_force_show: assert property (
    force_en_q && $stable(force_st_q) |=> status_q == ops_status_type'($past(force_st_q)))
    else $error("forced status not shown");
  chk_start_event: assert property (
    on_e[0] |=> pend_q[0] ##[0:5] s_emit_start) else $error("start event not issued");
  chk_log_fill: assert property (
    emit && !ev_sel[0] && lg_cnt_q < 4'(LOG_DEPTH) |=> lg_cnt_q == $past(lg_cnt_q) + 4'h1)
    else $error("log count not advanced");
  chk_cnt_clear: assert property (
    cnt_clr[1] && !on_e[1] |=> cnt_q[1] == 16'h0) else $error("counter not cleared");
endmodule

// ---- inc/ops_pkg.sv ----
/*
 * ops_pkg: constants, register map and types of the overpower stage.
 * Assumes a 10 MHz clock; power in units of 0.01 kW, times in 5 ms steps.
 */
package ops_pkg;
  // timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CYCLE_MS      = 5;
  localparam int unsigned CYCLE_CLKS    = CLK_HZ / 1000 * CYCLE_MS;
  localparam int unsigned PRE_TRIG_MS   = 20;
  localparam int unsigned PRE_FAULT_MS  = 200;
  localparam int unsigned PRE_TRIG_CYC  = PRE_TRIG_MS / CYCLE_MS;
  localparam int unsigned PRE_FAULT_CYC = PRE_FAULT_MS / CYCLE_MS;
  localparam int unsigned LOG_DEPTH     = 12;
  localparam int unsigned RESET_PCT     = 97;
  localparam int unsigned RATIO_SCALE   = 100;
  localparam int unsigned WATT_PER_LSB  = 10;
  // reset values
  localparam logic [31:0] THR_RST  = 32'h0000_2710;
  localparam logic [31:0] OPD_RST  = 32'h0000_0014;
  localparam logic [31:0] RSD_RST  = 32'h0000_0000;
  localparam logic [5:0]  MASK_RST = 6'h3F;
  // control fields
  localparam int unsigned CTRL_FORCE_EN = 0;
  localparam int unsigned CTRL_FORCE_LO = 1;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_THR    = 8'h04;
  localparam logic [7:0] OFS_OPD    = 8'h08;
  localparam logic [7:0] OFS_RSD    = 8'h0C;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_CLR    = 8'h14;
  localparam logic [7:0] OFS_STAT   = 8'h18;
  localparam logic [7:0] OFS_POWER  = 8'h1C;
  localparam logic [7:0] OFS_RATIO  = 8'h20;
  localparam logic [7:0] OFS_EXPECT = 8'h24;
  localparam logic [7:0] OFS_REMAIN = 8'h28;
  localparam logic [7:0] OFS_CNT0   = 8'h2C;
  localparam logic [7:0] OFS_CNT1   = 8'h30;
  localparam logic [7:0] OFS_CNT2   = 8'h34;
  localparam logic [7:0] OFS_LSEL   = 8'h38;
  localparam logic [7:0] OFS_LINFO  = 8'h3C;
  localparam logic [7:0] OFS_LPRE   = 8'h40;
  localparam logic [7:0] OFS_LFLT   = 8'h44;
  localparam logic [7:0] OFS_LPREF  = 8'h48;
  localparam logic [7:0] OFS_LREM   = 8'h4C;
  localparam logic [7:0] OFS_LDATE  = 8'h50;
  localparam logic [7:0] OFS_LTIME  = 8'h54;
  // event codes: even = ON, odd = OFF; pair k = start, trip, blocked
  localparam logic [2:0] EV_START_ON = 3'h0;
  typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED} ops_status_type;
endpackage

// ---- verif/ops_meas_model.sv ----
/*
 * ops_meas_model: stand-in for the measurement path and blocking matrix.
 * Assumes the bench changes targets only between processing ticks.
 */
`timescale 1ns/10ps
module ops_meas_model (
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic signed [15:0] p_cmd,
  input  wire logic signed [15:0] spl,
  input  wire logic               block_cmd,
  output logic signed [15:0]      i_l1,
  output logic signed [15:0]      i_l2,
  output logic signed [15:0]      i_l3,
  output logic [15:0]             u_l1,
  output logic [15:0]             u_l2,
  output logic [15:0]             u_l3,
  output logic                    block_in
);
  // phases 2 and 3 cancel, so a correct three-phase sum gives p_cmd
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      i_l1     <= 16'h0000;
      i_l2     <= 16'h0000;
      i_l3     <= 16'h0000;
      block_in <= 1'b0;
    end else begin
      i_l1     <= p_cmd;
      i_l2     <= spl;
      i_l3     <= -spl;
      block_in <= block_cmd;
    end
  end
  // fixed 10 V keeps power exact in 0.01 kW units
  assign u_l1 = 16'h000A;
  assign u_l2 = 16'h000A;
  assign u_l3 = 16'h000A;
endmodule

// ---- verif/tb.sv ----
/*
 * tb: self-checking bench for ops_stage against a behavioural stage model.
 * Assumes a 20-clock processing cycle and outputs two clocks after a tick.
 */
`timescale 1ns/10ps
module tb;
  import ops_pkg::*;
  logic clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, block_in, block_cmd = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, date_in = 32'h0, event_date, event_time, r;
  wire logic [31:0] time_ms_in;
  logic pready, pslverr, start_out, trip_out, blocked_out, event_valid, e;
  logic signed [15:0] i_l1, i_l2, i_l3, p_cmd = 16'h0000, spl = 16'h0000;
  logic [15:0] u_l1, u_l2, u_l3;
  logic [1:0] status_out;
  logic [2:0] event_code, setting_group = 3'h0;
  logic [5:0] msk;
  int cyc = 0, ph, st, tmr, thr = 10000, opd, log_n, log_code, log_p, err_total, n_compared;
  int cnt[3], q[$];
  bit ev_on = 1;
  ops_stage #(.P_CYCLE_CLKS(20)) uut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .i_l1, .i_l2, .i_l3, .u_l1, .u_l2, .u_l3,
    .block_in, .setting_group, .date_in, .time_ms_in, .start_out, .trip_out,
    .blocked_out, .status_out, .event_valid, .event_code, .event_date, .event_time);
  ops_meas_model far (.clock, .rst_n, .p_cmd, .spl, .block_cmd, .i_l1, .i_l2, .i_l3,
    .u_l1, .u_l2, .u_l3, .block_in);
  assign time_ms_in = 32'(cyc);
  // clock and cycle count; the count also cuts a hang short
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_total++;
      end_sim();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim();
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one APB transfer, held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rv,
           output logic er);
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    // no local limit: only the cycle ceiling ends a stuck wait
    do @(posedge clock); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d, r, e);
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0, r, e);
    chk(nm, r, exp);
  endtask
  function automatic logic [2:0] outs(input int s);
    return {s == 3, s == 2, s == 1 || s == 2};
  endfunction
  // behavioural stage: one evaluation per tick with the sampled inputs
  task mstep(input int p, input bit b);
    int ns;
    bit hold;
    logic [2:0] o, n;
    ns = st;
    hold = (p * 100 >= thr * 97) && !b;
    case (st)
      0: if (p > thr) begin ns = b ? 3 : 1; tmr = 0; end
      1: if (!hold) begin ns = 0; tmr = 0; end
         else begin tmr++; if (tmr >= (opd < 2 ? 1 : opd)) ns = 2; end
      2: if (!hold) ns = 0;
      3: if (p * 100 < thr * 97) ns = 0; else if (!b) begin ns = 1; tmr = 0; end
    endcase
    o = outs(st);
    n = outs(ns);
    for (int k = 0; k < 6; k++) begin
      if ((k % 2 == 0) ? (n[k/2] && !o[k/2]) : (o[k/2] && !n[k/2])) begin
        if (msk[k]) q.push_back(k);
        if (k % 2 == 0) begin cnt[k/2]++; log_n++; log_code = k; log_p = p; end
      end
    end
    st = ns;
  endtask
  task step(input int p, input bit b, input int n);
    p_cmd <= 16'(p); block_cmd <= b; spl <= 16'($urandom_range(0, 900));
    repeat (n) begin
      do @(posedge clock); while (cyc % 20 != ph);
      mstep(p, b);
      repeat (3) @(posedge clock);
      chk("status", 32'(status_out), st);
      rc("remain", OFS_REMAIN, st == 1 ? opd - tmr : 0);
    end
  endtask
  // emitted events against the model's queue
  always @(posedge clock) if (ev_on && event_valid === 1'b1) begin
    chk("event", 32'(event_code), q.size() > 0 ? q.pop_front() : 7);
    chk("stamp", event_date, date_in);
    chk("time", event_time, 32'(cyc - 1));
  end
  initial begin
    void'($urandom(25566));
    msk = 6'($urandom) | 6'h01;
    repeat (4) @(posedge clock);
    setting_group <= 3'($urandom);
    date_in <= $urandom;
    rst_n <= 1;
    rc("thr", OFS_THR, 32'h0000_2710);
    rc("expect", OFS_EXPECT, 32'h0000_0014);
    rc("mask", OFS_MASK, 32'h0000_003F);
    apb(0, 8'hFC, 32'h0, r, e);
    chk("unmapped", r, 32'h0);
    chk("slverr", 32'(e), 32'h1);
    wr(OFS_THR, 32'h0);
    rc("thr", OFS_THR, 32'h1);
    wr(OFS_THR, 32'h0000_2710);
    opd = 3;
    wr(OFS_OPD, 32'h3);
    wr(OFS_MASK, 32'(msk));
    rc("expect", OFS_EXPECT, 32'h3);
    // the first start fixes the tick phase for the model
    p_cmd <= 16'sd12000;
    for (int i = 0; i < 100 && start_out !== 1'b1; i++) @(posedge clock);
    chk("start", 32'(start_out), 32'h1);
    ph = (cyc - 3) % 20;
    st = 0;
    mstep(12000, 0);
    rc("power", OFS_POWER, 32'd12000);
    rc("ratio", OFS_RATIO, 32'd120);
    step(12000, 0, 3);
    step(9700, 0, 2);
    step(9699, 0, 1);
    step(10000, 0, 1);
    step(10001, 0, 2);
    step(10001, 1, 2);
    step(10001, 0, 1);
    step(5000, 0, 1);
    // threshold raised while started drops the stage
    step(12000, 0, 1);
    wr(OFS_THR, 32'd13000);
    thr = 13000;
    step(12000, 0, 1);
    wr(OFS_THR, 32'd10000);
    thr = 10000;
    for (int i = 0; i < 8; i++) begin step(12000, 0, 1); step(0, 0, 1); end
    wr(OFS_LSEL, 32'h0);
    rc("linfo", OFS_LINFO, (log_n > 12 ? 12 : log_n) << 8 | setting_group << 4 | log_code);
    rc("lfault", OFS_LFLT, log_p);
    rc("lrem", OFS_LREM, opd);
    rc("ldate", OFS_LDATE, date_in);
    wr(OFS_LSEL, 32'h10);
    rc("lsel", OFS_LSEL, 32'd11);
    for (int k = 0; k < 3; k++) rc("count", 8'(OFS_CNT0 + 4 * k), cnt[k]);
    wr(OFS_CLR, 32'h7);
    rc("count", OFS_CNT0, 32'h0);
    chk("pending", q.size(), 32'h0);
    // forced states; the forced edges are not in the model's event list
    ev_on = 0;
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL, 32'(s << 1 | 1));
      repeat (45) @(posedge clock);
      chk("forced", 32'(status_out), s);
      chk("outputs", 32'({blocked_out, trip_out, start_out}), 32'(outs(s)));
    end
    wr(OFS_CTRL, 32'h0);
    end_sim();
  end
endmodule
